/* File: inc/rocm_params.svh */
// constants for the relay output configuration matrix: offsets, fields, resets, timing
// assumes a 100 MHz core clock and a 32-bit wishbone slave with byte addresses
`ifndef ROCM_PARAMS_SVH
`define ROCM_PARAMS_SVH

`define ROCM_ADR_W 8
`define ROCM_OFS_LATCH_BF 8'h00
`define ROCM_OFS_IND_SEL 8'h04
`define ROCM_OFS_RC_ONE 8'h08
`define ROCM_OFS_RC_TWO 8'h0c
`define ROCM_OFS_RC_THREE 8'h10
`define ROCM_OFS_CI_ONE 8'h14
`define ROCM_OFS_CI_TWO 8'h18
`define ROCM_OFS_CI_THREE 8'h1c
`define ROCM_OFS_BF_TIME 8'h20
`define ROCM_OFS_STATUS 8'h24
`define ROCM_OFS_CMD 8'h28

`define ROCM_RST_LATCH_BF 8'h00
`define ROCM_RST_IND_SEL 8'haa
`define ROCM_RST_GROUP 8'h00

`define ROCM_F_HOLD_LSB 0
`define ROCM_F_BF_LSB 4
`define ROCM_MASK_LATCH_BF 8'h7f
`define ROCM_MASK_RC_SHORT 8'h3f
`define ROCM_F_CI_SETTING 4
`define ROCM_F_CI_AUX 5
`define ROCM_F_CI_LATCH 6
`define ROCM_F_CI_ALL 7
`define ROCM_F_CMD_LATCH 0
`define ROCM_F_CMD_IND 1

`define ROCM_CLK_MHZ 100
`define ROCM_BF_TIME_US 10
`define ROCM_BF_CYCLES (`ROCM_BF_TIME_US * `ROCM_CLK_MHZ)

`endif

/* File: inc/rocm_pkg.sv */
// types shared by the relay output configuration matrix
// assumes nothing beyond the constants header
package rocm_pkg;
	typedef enum logic [2:0] {
		BF_IDLE = 3'b001,
		BF_TIMING = 3'b010,
		BF_OPERATE = 3'b100
	} rocm_bf_state_t;
	typedef logic [7:0] rocm_group_t;
endpackage

/* File: core/rocm_sync.sv */
// two-flop synchroniser for pins arriving from outside the core clock domain
// assumes the inputs are slow levels, not pulses shorter than two cycles
`timescale 1ns/1ns
`default_nettype none
module rocm_sync #(
	parameter int W = 4
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // rocm_sync
`default_nettype wire

/* File: core/rocm_trip_latch.sv */
// self-holding stage for the trip outputs, one latch per output
// assumes trip requests come from logic on the core clock
`timescale 1ns/1ns
`default_nettype none
module rocm_trip_latch #(
	parameter int N = 4
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [N-1:0] trip_req,
	input wire logic [N-1:0] hold_sel,
	input wire logic clear,
	output logic [N-1:0] trip_out,
	output logic [N-1:0] latched
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_out
			wire logic latch_nxt;
			// a new request wins over a clear in the same cycle
			assign latch_nxt = hold_sel[i] & (trip_req[i] | (latched[i] & ~clear));
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					latched[i] <= 1'b0;
					trip_out[i] <= 1'b0;
				end else begin
					latched[i] <= latch_nxt;
					trip_out[i] <= trip_req[i] | latch_nxt;
				end
			end
		end
	endgenerate
endmodule // rocm_trip_latch
`default_nettype wire

/* File: core/rocm_top.sv */
// output configuration matrix: trip self-holding, breaker-failure supervision,
// trip indicator selection, reclose routing and control-input functions
// assumes a classic wishbone master on core_clk; control pins are asynchronous
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "rocm_params.svh"
module rocm_top #(
	parameter int BF_W = 16
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`ROCM_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] trip_req,
	input wire logic [3:0] start_req,
	input wire logic [7:0] reclose_src,
	input wire logic blocking_input_one,
	input wire logic blocking_input_two,
	input wire logic remote_reset_input,
	input wire logic panel_reset_button,
	output logic trip_output_one,
	output logic trip_output_two,
	output logic trip_output_three,
	output logic trip_output_four,
	output logic trip_indicator,
	output logic reclose_start_line_one,
	output logic reclose_start_line_two,
	output logic reclose_start_line_three,
	output logic [4:0] stage_block,
	output logic second_setting_select,
	output logic register_reset
);
	import rocm_pkg::*;

	rocm_group_t latch_bf_r;
	rocm_group_t ind_sel_r;
	rocm_group_t rc_r [3];
	rocm_group_t ci_r [3];
	logic [BF_W-1:0] bf_time_r;
	logic [BF_W-1:0] bf_cnt_r;
	rocm_bf_state_t bf_state_r;
	rocm_bf_state_t bf_state_nxt;
	logic cmd_latch_r;
	logic cmd_ind_r;
	logic ind_r;
	logic [2:0] rc_line_r;
	logic [4:0] block_r;
	logic setting_r;
	logic regs_reset_r;
	logic [3:0] held_out;
	logic [3:0] latched;
	logic [3:0] start_q_r;
	logic [3:0] pin_sync;

	// ---- control pins, two flops before any logic
	rocm_sync #(.W(4)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in({panel_reset_button, remote_reset_input, blocking_input_two, blocking_input_one}),
		.sync_out(pin_sync)
	);
	wire logic [2:0] ci_level = pin_sync[2:0];
	wire logic panel_reset = pin_sync[3];

	// ---- control input functions
	wire logic [2:0] ci_latch_rst;
	wire logic [2:0] ci_ind_rst;
	wire logic [2:0] ci_all_rst;
	wire logic [2:0] ci_setting;
	wire logic [2:0][3:0] ci_block;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ci
			assign ci_block[g] = ci_r[g][3:0] & {4{ci_level[g]}};
			assign ci_setting[g] = ci_r[g][`ROCM_F_CI_SETTING] & ci_level[g];
			assign ci_all_rst[g] = ci_r[g][`ROCM_F_CI_ALL] & ci_level[g];
			assign ci_latch_rst[g] = (ci_r[g][`ROCM_F_CI_LATCH] | ci_r[g][`ROCM_F_CI_ALL]) & ci_level[g];
			// the aux switch of group one blocks the fifth stage; on the others it clears indicators
			assign ci_ind_rst[g] = ci_latch_rst[g] | ((g != 0) && ci_r[g][`ROCM_F_CI_AUX] && ci_level[g]);
		end
	endgenerate
	wire logic [4:0] block_nxt = {ci_r[0][`ROCM_F_CI_AUX] & ci_level[0],
		ci_block[0] | ci_block[1] | ci_block[2]};
	wire logic latch_clear = panel_reset | (|ci_latch_rst) | cmd_latch_r;
	wire logic ind_clear = panel_reset | (|ci_ind_rst) | cmd_ind_r;

	// ---- trip outputs with optional self-holding
	rocm_trip_latch #(.N(4)) u_latch (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.trip_req(trip_req),
		.hold_sel(latch_bf_r[`ROCM_F_HOLD_LSB +: 4]),
		.clear(latch_clear),
		.trip_out(held_out),
		.latched(latched)
	);

	// ---- breaker-failure supervision
	// only trip outputs two to four can start it; output one is where it lands
	wire logic [2:0] bf_en = latch_bf_r[`ROCM_F_BF_LSB +: 3];
	wire logic bf_start = |(held_out[3:1] & bf_en);
	wire logic bf_expired = (bf_cnt_r >= bf_time_r);
	always_comb begin
		bf_state_nxt = bf_state_r;
		case (bf_state_r)
			BF_IDLE: begin
				if (bf_start) begin
					bf_state_nxt = BF_TIMING;
				end
			end
			BF_TIMING: begin
				if (!bf_start) begin
					bf_state_nxt = BF_IDLE;
				end else if (bf_expired) begin
					bf_state_nxt = BF_OPERATE;
				end
			end
			BF_OPERATE: begin
				if (!bf_start) begin
					bf_state_nxt = BF_IDLE;
				end
			end
			default: bf_state_nxt = BF_IDLE;
		endcase
	end
	wire logic bf_operate = (bf_state_r == BF_OPERATE);
	wire logic bf_timing = (bf_state_r == BF_TIMING);
	wire logic [BF_W-1:0] bf_cnt_nxt = bf_timing ? bf_cnt_r + BF_W'(1) : '0;

	assign trip_output_one = held_out[0] | bf_operate;
	assign trip_output_two = held_out[1];
	assign trip_output_three = held_out[2];
	assign trip_output_four = held_out[3];

	// ---- trip indicator, sticky until an indicator reset
	wire logic [7:0] ind_src = {trip_output_four, start_q_r[3], trip_output_three, start_q_r[2],
		trip_output_two, start_q_r[1], trip_output_one, start_q_r[0]};
	wire logic ind_hit = |(ind_src & ind_sel_r);
	// a hit in the clearing cycle keeps the lamp lit
	wire logic ind_nxt = ind_hit | (ind_r & ~ind_clear);

	// ---- reclose routing
	wire logic [2:0] rc_nxt;
	generate
		for (g = 0; g < 3; g++) begin : g_rc
			assign rc_nxt[g] = |(reclose_src & rc_r[g]);
		end
	endgenerate

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bf_state_r <= BF_IDLE;
			bf_cnt_r <= '0;
			ind_r <= 1'b0;
			rc_line_r <= '0;
			block_r <= '0;
			setting_r <= 1'b0;
			regs_reset_r <= 1'b0;
			start_q_r <= '0;
		end else begin
			bf_state_r <= bf_state_nxt;
			bf_cnt_r <= bf_cnt_nxt;
			ind_r <= ind_nxt;
			rc_line_r <= rc_nxt;
			block_r <= block_nxt;
			setting_r <= |ci_setting;
			regs_reset_r <= |ci_all_rst;
			start_q_r <= start_req;
		end
	end
	assign trip_indicator = ind_r;
	assign reclose_start_line_one = rc_line_r[0];
	assign reclose_start_line_two = rc_line_r[1];
	assign reclose_start_line_three = rc_line_r[2];
	assign stage_block = block_r;
	assign second_setting_select = setting_r;
	assign register_reset = regs_reset_r;

	// ---- wishbone slave, one wait state, unmapped reads give zero
	wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire logic hit_latch_bf = (wb_adr_i == `ROCM_OFS_LATCH_BF);
	wire logic hit_ind = (wb_adr_i == `ROCM_OFS_IND_SEL);
	wire logic [2:0] hit_rc = {wb_adr_i == `ROCM_OFS_RC_THREE, wb_adr_i == `ROCM_OFS_RC_TWO,
		wb_adr_i == `ROCM_OFS_RC_ONE};
	wire logic [2:0] hit_ci = {wb_adr_i == `ROCM_OFS_CI_THREE, wb_adr_i == `ROCM_OFS_CI_TWO,
		wb_adr_i == `ROCM_OFS_CI_ONE};
	wire logic hit_bf_time = (wb_adr_i == `ROCM_OFS_BF_TIME);
	wire logic hit_status = (wb_adr_i == `ROCM_OFS_STATUS);
	wire logic hit_cmd = (wb_adr_i == `ROCM_OFS_CMD);
	wire logic [31:0] status_word = {18'h0, bf_timing, bf_operate, latched, ind_r, rc_line_r,
		trip_output_four, trip_output_three, trip_output_two, trip_output_one};
	wire logic [31:0] rd_mux =
		hit_latch_bf ? {24'h0, latch_bf_r} :
		hit_ind ? {24'h0, ind_sel_r} :
		hit_rc[0] ? {24'h0, rc_r[0]} :
		hit_rc[1] ? {24'h0, rc_r[1]} :
		hit_rc[2] ? {24'h0, rc_r[2]} :
		hit_ci[0] ? {24'h0, ci_r[0]} :
		hit_ci[1] ? {24'h0, ci_r[1]} :
		hit_ci[2] ? {24'h0, ci_r[2]} :
		hit_bf_time ? {{(32-BF_W){1'b0}}, bf_time_r} :
		hit_status ? status_word : 32'h0;
	// the byte written is the checksum: switch n carries weight two to the n minus one
	wire logic [7:0] wr_byte = wb_dat_i[7:0];

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_bf_r <= `ROCM_RST_LATCH_BF;
			ind_sel_r <= `ROCM_RST_IND_SEL;
			cmd_latch_r <= 1'b0;
			cmd_ind_r <= 1'b0;
			bf_time_r <= BF_W'(`ROCM_BF_CYCLES);
		end else begin
			if (bus_wr && hit_latch_bf) begin
				latch_bf_r <= wr_byte & `ROCM_MASK_LATCH_BF;
			end
			if (bus_wr && hit_ind) begin
				ind_sel_r <= wr_byte;
			end
			if (bus_req && wb_we_i && hit_bf_time && (&wb_sel_i[1:0])) begin
				bf_time_r <= wb_dat_i[BF_W-1:0];
			end
			// serial reset commands are one-cycle pulses
			cmd_latch_r <= bus_wr & hit_cmd & wb_dat_i[`ROCM_F_CMD_LATCH];
			cmd_ind_r <= bus_wr & hit_cmd & wb_dat_i[`ROCM_F_CMD_IND];
		end
	end

	generate
		for (g = 0; g < 3; g++) begin : g_grp
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					rc_r[g] <= `ROCM_RST_GROUP;
					ci_r[g] <= `ROCM_RST_GROUP;
				end else begin
					if (bus_wr && hit_rc[g]) begin
						// top two switches are dead on the first two lines
						rc_r[g] <= (g < 2) ? (wr_byte & `ROCM_MASK_RC_SHORT) : wr_byte;
					end
					if (bus_wr && hit_ci[g]) begin
						ci_r[g] <= wr_byte;
					end
				end
			end
		end
	endgenerate

	// ---- checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	logic [8:0] csum_ind;
	always_comb begin
		csum_ind = '0;
		for (int k = 0; k < 8; k++) begin
			csum_ind = csum_ind + (ind_sel_r[k] ? 9'(1 << k) : 9'h0);
		end
	end

	trip_release_a: assert property (!latch_bf_r[1] && !trip_req[1] ##1 !trip_req[1]
		|-> !trip_output_two) else $error("unheld trip output stayed high");
	trip_hold_a: assert property (latch_bf_r[2] && trip_output_three && !latch_clear
		&& $stable(latch_bf_r) |=> trip_output_three) else $error("held trip output dropped");
	latch_clear_a: assert property (latch_clear && !trip_req[3] ##1 !trip_req[3]
		|-> !trip_output_four) else $error("held trip output not cleared");
	bf_start_a: assert property ($rose(bf_start) && bf_state_r == BF_IDLE
		|=> bf_state_r == BF_TIMING) else $error("supervision did not start");
	bf_operate_a: assert property (bf_timing && bf_expired && bf_start
		|=> trip_output_one) else $error("expired timer gave no trip one");
	bf_disabled_a: assert property (bf_en == 3'h0 |-> !bf_start && !latch_bf_r[7])
		else $error("disabled supervision started");
	ind_light_a: assert property (ind_hit |=> trip_indicator)
		else $error("selected output did not light indicator");
	ind_default_a: assert property ($rose(reset_n) |-> ind_sel_r == 8'haa)
		else $error("indicator select not at default");
	reclose_or_a: assert property (|(reclose_src & rc_r[2]) && $stable(rc_r[2])
		|=> reclose_start_line_three) else $error("routed signal missed reclose line");
	reclose_dead_a: assert property (rc_r[0][7:6] == 2'b00 && rc_r[1][7:6] == 2'b00)
		else $error("dead routing switch set");
	ci_setting_a: assert property (ci_setting[1] |=> second_setting_select)
		else $error("setting input function missing");
	checksum_sum_a: assert property (csum_ind == {1'b0, ind_sel_r})
		else $error("checksum differs from weighted sum");
	stage_block_a: assert property (ci_r[0][0] && ci_level[0] |=> stage_block[0])
		else $error("blocked stage not blocked");
endmodule // rocm_top
`default_nettype wire

/* File: tb/rocm_field_model.sv */
// field-side model: protection stages presenting start, trip and reclose source signals
// assumes level commands from the bench on core_clk; outputs move just after the edge
`timescale 1ns/1ns
`default_nettype none
module rocm_field_model (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [3:0] cmd_trip,
	input wire logic [3:0] cmd_start,
	input wire logic [7:0] cmd_src,
	output logic [3:0] trip_req,
	output logic [3:0] start_req,
	output logic [7:0] reclose_src
);
	// stages stay quiet until reset is released
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			trip_req <= 4'h0;
			start_req <= 4'h0;
			reclose_src <= 8'h00;
		end else begin
			trip_req <= cmd_trip;
			start_req <= cmd_start;
			reclose_src <= cmd_src;
		end
	end
endmodule // rocm_field_model
`default_nettype wire

/* File: tb/tb_rocm_top.sv */
// bench for the relay output matrix: registers, self-hold, breaker failure, indicator, routing
// assumes rocm_top holds its own assertions; the field model drives the stage inputs
`timescale 1ns/1ns
`default_nettype none
module tb_rocm_top;
	logic core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i, reclose_src, cmd_src;
	logic [3:0] wb_sel_i, trip_req, start_req, cmd_trip, cmd_start, sh;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic blocking_input_one, blocking_input_two, remote_reset_input, panel_reset_button;
	logic trip_output_one, trip_output_two, trip_output_three, trip_output_four;
	logic trip_indicator, second_setting_select, register_reset;
	logic reclose_start_line_one, reclose_start_line_two, reclose_start_line_three;
	logic [4:0] stage_block;
	int err_total, samples_checked, i;

	rocm_top #(.BF_W(16)) u_rocm_top (.core_clk(core_clk), .reset_n(reset_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.trip_req(trip_req), .start_req(start_req), .reclose_src(reclose_src),
		.blocking_input_one(blocking_input_one), .blocking_input_two(blocking_input_two),
		.remote_reset_input(remote_reset_input), .panel_reset_button(panel_reset_button),
		.trip_output_one(trip_output_one), .trip_output_two(trip_output_two),
		.trip_output_three(trip_output_three), .trip_output_four(trip_output_four),
		.trip_indicator(trip_indicator), .reclose_start_line_one(reclose_start_line_one),
		.reclose_start_line_two(reclose_start_line_two),
		.reclose_start_line_three(reclose_start_line_three), .stage_block(stage_block),
		.second_setting_select(second_setting_select), .register_reset(register_reset));
	rocm_field_model u_rocm_field_model (.core_clk(core_clk), .reset_n(reset_n),
		.cmd_trip(cmd_trip), .cmd_start(cmd_start), .cmd_src(cmd_src), .trip_req(trip_req),
		.start_req(start_req), .reclose_src(reclose_src));

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one classic cycle; held until ack is sampled, then released for an idle cycle
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h3;
		wb_dat_i <= dat;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			$display("MISMATCH %0t bus timeout", $time);
			close_out();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb_xfer(1'b1, adr, dat);
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
		wb_xfer(1'b0, adr, 32'h0);
		chk(q, exp, what);
	endtask
	// watches trip one for a window; operate must not come before the timer runs out
	task automatic bf_try(input logic [3:0] t, input logic e);
		int at;
		at = 0;
		cmd_trip <= t;
		for (int n = 1; n <= 30; n++) begin
			@(posedge core_clk);
			if (trip_output_one === 1'b1 && at == 0) at = n;
		end
		chk(32'(at != 0), 32'(e), "bf operate");
		if (e) chk(32'(at > 6), 32'h1, "bf too early");
		cmd_trip <= 4'h0;
		tick(4);
		chk(32'(trip_output_one), 32'h0, "bf release");
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		reset_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		{cmd_trip, cmd_start, cmd_src} = 16'h0000;
		{blocking_input_one, blocking_input_two} = 2'h0;
		{remote_reset_input, panel_reset_button} = 2'h0;
		err_total = 0;
		samples_checked = 0;
		tick(6);
		reset_n <= 1'b1;
		rd_chk(8'h00, 32'h0, "hold reset");
		rd_chk(8'h04, 32'haa, "ind reset");
		rd_chk(8'h20, 32'h3e8, "bf time reset");
		rd_chk(8'h30, 32'h0, "unmapped");
		wr(8'h00, 32'hff);
		rd_chk(8'h00, 32'h7f, "bit8 unused");
		wr(8'h08, 32'hc1);
		rd_chk(8'h08, 32'h01, "rc1 sw78");
		wr(8'h0c, 32'hc2);
		rd_chk(8'h0c, 32'h02, "rc2 sw78");
		wr(8'h10, 32'h80);
		rd_chk(8'h10, 32'h80, "rc3 byte");
		$display("test registers done");
		for (i = 0; i < 8; i++) begin
			cmd_src <= 8'h01 << i;
			tick(4);
			chk({29'h0, reclose_start_line_three, reclose_start_line_two, reclose_start_line_one},
				{29'h0, i == 7, i == 1, i == 0}, "reclose");
		end
		cmd_src <= 8'h00;
		$display("test routing done");
		wr(8'h00, 32'h0);
		cmd_trip <= 4'h4;
		tick(3);
		chk(32'(trip_output_three), 32'h1, "follow on");
		cmd_trip <= 4'h0;
		tick(3);
		chk(32'(trip_output_three), 32'h0, "follow off");
		wr(8'h1c, 32'h40);
		wr(8'h00, 32'h0c);
		for (i = 0; i < 3; i++) begin
			cmd_trip <= 4'hc;
			tick(3);
			cmd_trip <= 4'h0;
			tick(4);
			chk(32'(trip_output_four), 32'h1, "held");
			// trips three and four, lamp lit, both latched
			rd_chk(8'h24, 32'hc8c, "status held");
			if (i == 0) wr(8'h28, 32'h1);
			else if (i == 1) panel_reset_button <= 1'b1;
			else remote_reset_input <= 1'b1;
			tick(6);
			{panel_reset_button, remote_reset_input} <= 2'h0;
			chk(32'(trip_output_four), 32'h0, "cleared");
		end
		$display("test self-hold done");
		wr(8'h20, 32'h5);
		wr(8'h00, 32'h10);
		bf_try(4'h2, 1'b1);
		wr(8'h00, 32'h60);
		bf_try(4'h2, 1'b0);
		bf_try(4'h4, 1'b1);
		bf_try(4'h8, 1'b1);
		wr(8'h00, 32'h0);
		$display("test breaker failure done");
		// the lamp is sticky from the earlier trips; start from dark
		wr(8'h28, 32'h2);
		for (i = 0; i < 8; i++) begin
			sh = 4'h1 << (i / 2);
			wr(8'h04, 32'h1 << i);
			{cmd_trip, cmd_start} <= (i % 2) ? {4'h0, sh} : {sh, 4'h0};
			tick(5);
			chk(32'(trip_indicator), 32'h0, "ind unselected");
			{cmd_trip, cmd_start} <= (i % 2) ? {sh, 4'h0} : {4'h0, sh};
			tick(5);
			chk(32'(trip_indicator), 32'h1, "ind selected");
			{cmd_trip, cmd_start} <= 8'h00;
			tick(3);
			wr(8'h28, 32'h2);
			tick(3);
			chk(32'(trip_indicator), 32'h0, "ind reset");
		end
		$display("test indicator done");
		wr(8'h14, 32'h01);
		wr(8'h18, 32'h10);
		wr(8'h1c, 32'h04);
		blocking_input_one <= 1'b1;
		tick(6);
		chk(32'(stage_block), 32'h01, "block one");
		{blocking_input_two, remote_reset_input} <= 2'h3;
		tick(6);
		chk(32'({second_setting_select, stage_block}), 32'h25, "ctrl funcs");
		{blocking_input_one, blocking_input_two, remote_reset_input} <= 3'h0;
		tick(6);
		chk(32'({second_setting_select, stage_block}), 32'h0, "ctrl low");
		wr(8'h1c, 32'h80);
		remote_reset_input <= 1'b1;
		tick(6);
		chk(32'(register_reset), 32'h1, "all reset");
		remote_reset_input <= 1'b0;
		tick(6);
		chk(32'(register_reset), 32'h0, "all reset low");
		$display("test control inputs done");
		close_out();
	end
endmodule // tb_rocm_top
`default_nettype wire
